// ==== logic/wcb_pkg.sv ====
// constants shared by the wide event counter bank
package wcb_pkg;
    localparam int NUM_CTR = 256;
    localparam int IDX_W = 8;
    localparam int VAL_W = 32;
    localparam int HALF_W = 16;
    localparam logic [IDX_W-1:0] GEN_LAST = 8'h3F;
    localparam logic [IDX_W-1:0] UP_LAST = 8'hC7;
    localparam logic [IDX_W-1:0] IDX_LAST = 8'hFF;
    localparam logic [IDX_W-1:0] IDX_ZERO = 8'h00;
    localparam logic [VAL_W-1:0] VAL_MAX = 32'h7FFFFFFF;
    localparam logic [VAL_W-1:0] VAL_MIN = 32'h80000000;
    localparam logic [VAL_W-1:0] VAL_ZERO = 32'h00000000;
    localparam logic [VAL_W-1:0] VAL_ONE = 32'h00000001;
    localparam logic [NUM_CTR-1:0] BITS_ZERO = '0;

    typedef enum logic [1:0] {
        ST_SWEEP,
        ST_IDLE,
        ST_EXEC
    } wcb_state_type;

    // counters 0..63 take their own direction bit, 64..199 count up only
    function automatic logic wcb_counts_up(input logic [IDX_W-1:0] idx, input logic [NUM_CTR/4-1:0] dir_sel,
                                           input logic hs_down);
        if (idx <= GEN_LAST) begin
            return !dir_sel[idx[5:0]];
        end else if (idx <= UP_LAST) begin
            return 1'b1;
        end else begin
            return !hs_down;
        end
    endfunction
endpackage

// ==== logic/wcb_value_ram.sv ====
// present count value storage, one 32-bit word per counter, registered read
`timescale 1ns/100ps
`default_nettype none
module wcb_value_ram
    import wcb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [IDX_W-1:0] i_waddr,
    input wire logic [VAL_W-1:0] i_wdata,
    input wire logic [IDX_W-1:0] i_raddr,
    output logic [VAL_W-1:0] o_rdata
);
    logic [VAL_W-1:0] mem [NUM_CTR];

    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule
`default_nettype wire

// ==== logic/wcb_count_step.sv ====
// one counting step: next value with signed wrap and the contact it leaves
`timescale 1ns/100ps
`default_nettype none
module wcb_count_step
    import wcb_pkg::*;
(
    input wire logic [VAL_W-1:0] i_value,
    input wire logic [VAL_W-1:0] i_setpoint,
    input wire logic i_up,
    input wire logic i_step,
    input wire logic i_contact,
    output logic [VAL_W-1:0] o_next,
    output logic o_contact
);
    always_comb begin
        o_next = i_value;
        o_contact = i_contact;
        if (i_step) begin
            // plain modulo arithmetic gives the signed wrap in both directions
            o_next = i_up ? VAL_W'(i_value + VAL_ONE) : VAL_W'(i_value - VAL_ONE);
            if (i_up && o_next == i_setpoint) begin
                o_contact = 1'b1;
            end
            // leaving the setpoint downward drops the contact too, so -5 to -6 turns it off
            if (!i_up && (o_next == i_setpoint || i_value == i_setpoint)) begin
                o_contact = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/wcb_counter_bank.sv ====
// bank of 256 signed 32-bit event counters served one request at a time
// Functional notes
// - each value and setpoint is a 32-bit two's complement number over the full signed range.
// - counters 0-63 count up or down, 64-199 count up only, 200 and above are bidirectional.
// - a general bidirectional counter counts up with its direction bit clear and down with it set.
// - counting goes on past the setpoint rather than stopping there.
// - an up-counting counter that reaches its setpoint turns its contact on.
// - a down-counting counter that reaches its setpoint turns its contact off.
// - with setpoint -5 the contact goes on at -6 to -5 and off at -5 to -6.
// - a reset request clears the value to zero and forces the contact off.
// - counting up from the largest positive value gives the most negative value.
// - counting down from the most negative value gives the largest positive value.
// - the setpoint is either a constant or a 32-bit pair of 16-bit data words.
// - of the data word pair, the lower-numbered word is the low half.
// - after a power interruption every non-latched counter is cleared.
// - a latched counter keeps value and contact through a power interruption and counts on from there.
// - each off-to-on change of the count input without a reset request moves the value by exactly one.
// - the visible contact changes only when the scan is complete.
`timescale 1ns/100ps
`default_nettype none
module wcb_counter_bank
    import wcb_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic i_CE,
    input wire logic i_REQ,
    input wire logic [IDX_W-1:0] i_IDX,
    input wire logic i_COUNT_IN,
    input wire logic i_RESET_REQ,
    input wire logic i_HS_DOWN,
    input wire logic i_SP_FROM_DATA,
    input wire logic [VAL_W-1:0] i_SP_CONST,
    input wire logic [HALF_W-1:0] i_SP_LOW_WORD,
    input wire logic [HALF_W-1:0] i_SP_HIGH_WORD,
    input wire logic [NUM_CTR/4-1:0] i_DIR_SEL,
    input wire logic [IDX_W:0] i_LATCH_BASE,
    input wire logic i_POWER_RESTORE,
    input wire logic i_SCAN_END,
    output logic o_READY,
    output logic o_DONE,
    output logic [VAL_W-1:0] o_VALUE,
    output logic [NUM_CTR-1:0] o_CONTACT
);
    wcb_state_type state, next_state;
    logic [IDX_W-1:0] idx, next_idx;
    logic count_in, next_count_in;
    logic reset_req, next_reset_req;
    logic up, next_up;
    logic [VAL_W-1:0] setpoint, next_setpoint;
    logic sweep_all, next_sweep_all;
    logic [NUM_CTR-1:0] prev_in, next_prev_in;
    logic [NUM_CTR-1:0] contact_work, next_contact_work;
    logic [NUM_CTR-1:0] next_contact_out;
    logic [VAL_W-1:0] next_value;
    logic next_done;
    logic ram_we;
    logic [IDX_W-1:0] ram_raddr;
    logic [VAL_W-1:0] ram_wdata;
    logic [VAL_W-1:0] ram_rdata;
    logic rise;
    logic sweep_clear;
    logic [VAL_W-1:0] step_value;
    logic step_contact;

    wcb_value_ram u_ram (
        .i_clk(I_CLK),
        .i_ce(i_CE),
        .i_we(ram_we),
        .i_waddr(idx),
        .i_wdata(ram_wdata),
        .i_raddr(ram_raddr),
        .o_rdata(ram_rdata)
    );

    // reset wins over a simultaneous edge, so no step is offered then
    assign rise = count_in && !prev_in[idx] && !reset_req;

    wcb_count_step u_step (
        .i_value(ram_rdata),
        .i_setpoint(setpoint),
        .i_up(up),
        .i_step(rise),
        .i_contact(contact_work[idx]),
        .o_next(step_value),
        .o_contact(step_contact)
    );

    // latched counters sit at and above the latch base
    assign sweep_clear = sweep_all || ({1'b0, idx} < i_LATCH_BASE);
    assign o_READY = (state == ST_IDLE) && !i_POWER_RESTORE;
    assign ram_raddr = i_IDX;

    always_comb begin
        next_state = state;
        next_idx = idx;
        next_count_in = count_in;
        next_reset_req = reset_req;
        next_up = up;
        next_setpoint = setpoint;
        next_sweep_all = sweep_all;
        next_prev_in = prev_in;
        next_contact_work = contact_work;
        next_value = o_VALUE;
        next_done = 1'b0;
        ram_we = 1'b0;
        ram_wdata = VAL_ZERO;
        case (state)
            ST_SWEEP: begin
                if (sweep_clear) begin
                    ram_we = 1'b1;
                    next_contact_work[idx] = 1'b0;
                    next_prev_in[idx] = 1'b0;
                end
                next_idx = IDX_W'(idx + 8'h01);
                if (idx == IDX_LAST) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_POWER_RESTORE) begin
                    next_state = ST_SWEEP;
                    next_sweep_all = 1'b0;
                    next_idx = IDX_ZERO;
                end else if (i_REQ) begin
                    next_state = ST_EXEC;
                    next_idx = i_IDX;
                    next_count_in = i_COUNT_IN;
                    next_reset_req = i_RESET_REQ;
                    next_up = wcb_counts_up(i_IDX, i_DIR_SEL, i_HS_DOWN);
                    // data words pair low word first into one signed setpoint
                    next_setpoint = i_SP_FROM_DATA ? {i_SP_HIGH_WORD, i_SP_LOW_WORD} : i_SP_CONST;
                end
            end
            ST_EXEC: begin
                ram_we = 1'b1;
                next_prev_in[idx] = count_in;
                next_done = 1'b1;
                next_state = ST_IDLE;
                if (reset_req) begin
                    ram_wdata = VAL_ZERO;
                    next_contact_work[idx] = 1'b0;
                end else begin
                    ram_wdata = step_value;
                    next_contact_work[idx] = step_contact;
                end
                next_value = ram_wdata;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // the contact seen outside follows the working copy only at scan end
    always_comb begin
        next_contact_out = o_CONTACT;
        if (i_SCAN_END) begin
            next_contact_out = next_contact_work;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_NRST) begin
            state <= ST_SWEEP;
            idx <= IDX_ZERO;
            count_in <= 1'b0;
            reset_req <= 1'b0;
            up <= 1'b1;
            setpoint <= VAL_ZERO;
            sweep_all <= 1'b1;
            prev_in <= BITS_ZERO;
            contact_work <= BITS_ZERO;
            o_VALUE <= VAL_ZERO;
            o_DONE <= 1'b0;
            o_CONTACT <= BITS_ZERO;
        end else if (i_CE) begin
            state <= next_state;
            idx <= next_idx;
            count_in <= next_count_in;
            reset_req <= next_reset_req;
            up <= next_up;
            setpoint <= next_setpoint;
            sweep_all <= next_sweep_all;
            prev_in <= next_prev_in;
            contact_work <= next_contact_work;
            o_VALUE <= next_value;
            o_DONE <= next_done;
            o_CONTACT <= next_contact_out;
        end
    end

    // checks
    logic exec;
    assign exec = (state == ST_EXEC) && i_CE;
    logic take;
    assign take = o_READY && i_REQ && i_CE;

    AST_RESET_CLEARS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && reset_req |=> o_VALUE == VAL_ZERO && !contact_work[$past(idx)])
        else $error("reset request did not clear value and contact");

    AST_RESET_BEATS_EDGE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && reset_req && count_in && !prev_in[idx] |=> o_VALUE == VAL_ZERO)
        else $error("count edge was applied together with a reset");

    AST_STEP_UP: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && up |=> o_VALUE == vw_add($past(ram_rdata)))
        else $error("up count did not add exactly one");

    AST_STEP_DOWN: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up |=> o_VALUE == VAL_W'($past(ram_rdata) - VAL_ONE))
        else $error("down count did not subtract exactly one");

    AST_NO_EDGE_HOLDS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && !reset_req && !rise |=> o_VALUE == $past(ram_rdata))
        else $error("value changed without a count edge");

    AST_WRAP_UP: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && up && ram_rdata == VAL_MAX |=> o_VALUE == VAL_MIN)
        else $error("up wrap wrong");

    AST_WRAP_DOWN: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up && ram_rdata == VAL_MIN |=> o_VALUE == VAL_MAX)
        else $error("down wrap wrong");

    AST_CONTACT_MATCH: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && step_value == setpoint |=> contact_work[$past(idx)] == $past(up))
        else $error("contact did not follow setpoint match");

    AST_UP_ONLY: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == ST_EXEC && idx > GEN_LAST && idx <= UP_LAST |-> up)
        else $error("up-only counter set to count down");

    AST_PUBLISH_AT_SCAN_END: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        i_CE && !i_SCAN_END |=> $stable(o_CONTACT))
        else $error("visible contact changed outside scan end");

    AST_PUBLISH_WORKING: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        i_CE && i_SCAN_END |=> o_CONTACT == $past(next_contact_work))
        else $error("scan end did not publish the working contacts");

    AST_UP_REACH_ON: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && up && step_value == setpoint |=> contact_work[$past(idx)])
        else $error("up count onto setpoint left contact off");

    AST_DOWN_REACH_OFF: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up && step_value == setpoint |=> !contact_work[$past(idx)])
        else $error("down count onto setpoint left contact on");

    AST_DOWN_LEAVE_SETPOINT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up && ram_rdata == setpoint |=> !contact_work[$past(idx)])
        else $error("down count off setpoint left contact on");

    AST_CONTACT_KEPT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && step_value != setpoint && ram_rdata != setpoint
        |=> contact_work[$past(idx)] == $past(contact_work[idx]))
        else $error("contact changed away from the setpoint");

    AST_LAST_LEVEL_KEPT: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        exec |=> prev_in[$past(idx)] == $past(count_in))
        else $error("count input level not recorded");

    AST_DONE_PULSE: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        i_CE |=> o_DONE == $past(exec))
        else $error("done pulse not tied to the execute cycle");

    // sweep and request capture
    AST_SWEEP_CLEARS: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == ST_SWEEP && i_CE && sweep_clear |=> !contact_work[$past(idx)] && !prev_in[$past(idx)])
        else $error("sweep left a non-latched counter set");

    AST_SWEEP_KEEPS_LATCHED: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        state == ST_SWEEP && i_CE && !sweep_clear |=> contact_work[$past(idx)] == $past(contact_work[idx]))
        else $error("sweep disturbed a latched contact");

    AST_SETPOINT_PAIR: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        take && i_SP_FROM_DATA |=> setpoint == {$past(i_SP_HIGH_WORD), $past(i_SP_LOW_WORD)})
        else $error("data word pair taken in the wrong order");

    AST_SETPOINT_CONST: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        take && !i_SP_FROM_DATA |=> setpoint == $past(i_SP_CONST))
        else $error("constant setpoint not taken");

    AST_GENERAL_DIRECTION: assert property (@(posedge I_CLK) disable iff (!I_NRST)
        take && i_IDX <= GEN_LAST |=> up == !$past(i_DIR_SEL[i_IDX[5:0]]))
        else $error("general counter direction does not follow its bit");

    COV_STEP_UP: cover property (@(posedge I_CLK) disable iff (!I_NRST) exec && rise && up);
    COV_STEP_DOWN_MATCH: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up && step_value == setpoint);
    COV_RESET_WITH_EDGE: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && reset_req && count_in && !prev_in[idx]);
    COV_POWER_SWEEP: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        state == ST_IDLE && i_POWER_RESTORE && i_CE);
    COV_DOWN_LEAVE_SETPOINT: cover property (@(posedge I_CLK) disable iff (!I_NRST)
        exec && rise && !up && ram_rdata == setpoint);

    function automatic logic [VAL_W-1:0] vw_add(input logic [VAL_W-1:0] v);
        return VAL_W'(v + VAL_ONE);
    endfunction
endmodule
`default_nettype wire

// ==== verif/wcb_scan_model.sv ====
// scan model: the controller program issuing counter requests and scan ends
`timescale 1ns/100ps
`default_nettype none
module wcb_scan_model
    import wcb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_done,
    input wire logic [VAL_W-1:0] i_value,
    output logic o_req,
    output logic [IDX_W-1:0] o_idx,
    output logic o_count,
    output logic o_reset,
    output logic o_scan_end
);
    initial begin
        o_req = 1'b0;
        o_idx = IDX_ZERO;
        o_count = 1'b0;
        o_reset = 1'b0;
        o_scan_end = 1'b0;
    end
    // request held until taken; released fields turn to junk so stale values never help
    task automatic issue(input logic [IDX_W-1:0] k, input logic c, input logic r,
                         output logic [VAL_W-1:0] v, output logic ok);
        int n;
        logic rdy;
        rdy = 1'b0;
        ok = 1'b0;
        @(posedge i_clk);
        o_req <= 1'b1;
        o_idx <= k;
        o_count <= c;
        o_reset <= r;
        for (n = 0; n < 600 && !rdy; n++) begin
            @(negedge i_clk);
            rdy = i_ready;
        end
        @(posedge i_clk);
        o_req <= 1'b0;
        o_idx <= ~k;
        o_count <= ~c;
        o_reset <= ~r;
        for (n = 0; n < 4 && rdy && !ok; n++) begin
            @(negedge i_clk);
            ok = i_done;
        end
        v = i_value;
    endtask
    task automatic mark_end();
        @(posedge i_clk);
        o_scan_end <= 1'b1;
        @(posedge i_clk);
        o_scan_end <= 1'b0;
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the wide event counter bank
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import wcb_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, hs_down = 1'b0, sp_from_data = 1'b0, pwr = 1'b0;
    logic req, count_in, reset_req, scan_end, ready, done;
    logic [IDX_W-1:0] idx;
    logic [IDX_W:0] latch_base = 9'h100;
    logic [VAL_W-1:0] sp_const = 32'hFFFFFFFB, value;
    logic [HALF_W-1:0] sp_lo = 16'h0002, sp_hi = 16'h0000;
    logic [NUM_CTR/4-1:0] dir_sel = '0;
    logic [NUM_CTR-1:0] contact, m_con = '0, m_pub = '0, m_last = '0;
    logic [VAL_W-1:0] m_val [NUM_CTR];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    wcb_counter_bank i_dut (.I_CLK(clk), .I_NRST(nrst), .i_CE(1'b1), .i_REQ(req), .i_IDX(idx),
        .i_COUNT_IN(count_in), .i_RESET_REQ(reset_req), .i_HS_DOWN(hs_down), .i_SP_FROM_DATA(sp_from_data),
        .i_SP_CONST(sp_const), .i_SP_LOW_WORD(sp_lo), .i_SP_HIGH_WORD(sp_hi), .i_DIR_SEL(dir_sel),
        .i_LATCH_BASE(latch_base), .i_POWER_RESTORE(pwr), .i_SCAN_END(scan_end), .o_READY(ready),
        .o_DONE(done), .o_VALUE(value), .o_CONTACT(contact));
    wcb_scan_model i_scan (.i_clk(clk), .i_ready(ready), .i_done(done), .i_value(value), .o_req(req),
        .o_idx(idx), .o_count(count_in), .o_reset(reset_req), .o_scan_end(scan_end));
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [NUM_CTR-1:0] got, input logic [NUM_CTR-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic goes_up(input logic [IDX_W-1:0] k);
        if (k < 8'h40) return !dir_sel[k[5:0]];
        if (k < 8'hC8) return 1'b1;
        return !hs_down;
    endfunction
    // expectation is worked out after the request so that config updates have landed
    task automatic do_req(input logic [IDX_W-1:0] k, input logic c, input logic r);
        logic [VAL_W-1:0] got, sp, nv;
        logic ok, up;
        i_scan.issue(k, c, r, got, ok);
        sp = sp_from_data ? {sp_hi, sp_lo} : sp_const;
        up = goes_up(k);
        nv = m_val[k];
        if (r) begin
            nv = VAL_ZERO;
            m_con[k] = 1'b0;
        end else if (c && !m_last[k]) begin
            nv = up ? nv + VAL_ONE : nv - VAL_ONE;
            if (up && nv == sp) begin
                m_con[k] = 1'b1;
            end
            if (!up && (nv == sp || m_val[k] == sp)) begin
                m_con[k] = 1'b0;
            end
        end
        m_last[k] = c;
        m_val[k] = nv;
        check(ok ? got : ~nv, nv);
        check(contact, m_pub);
    endtask
    task automatic pulse(input logic [IDX_W-1:0] k, input int n);
        repeat (n) begin
            do_req(k, 1'b1, 1'b0);
            do_req(k, 1'b0, 1'b0);
        end
    endtask
    task automatic scan();
        i_scan.mark_end();
        m_pub = m_con;
        check(contact, m_pub);
    endtask
    task automatic power(input logic [IDX_W:0] base);
        @(posedge clk);
        latch_base <= base;
        pwr <= 1'b1;
        @(posedge clk);
        pwr <= 1'b0;
        // cleared contacts may only be published once the sweep is over
        @(negedge clk);
        while (!ready) @(negedge clk);
        for (int k = 0; k < NUM_CTR; k++) begin
            if (k < base) begin
                m_val[k] = VAL_ZERO;
                m_con[k] = 1'b0;
                m_last[k] = 1'b0;
            end
        end
    endtask
    initial begin
        int i;
        logic [IDX_W-1:0] pick [4];
        pick = '{8'h01, 8'h50, 8'hE0, 8'h3E};
        foreach (m_val[k]) m_val[k] = VAL_ZERO;
        i = $urandom(32'hA8C0);
        repeat (10) @(posedge clk);
        check(value, VAL_ZERO);
        check(contact, m_pub);
        nrst <= 1'b1;
        // setpoint -5 on counter 0: down to -6, up to -5, down again
        dir_sel[0] <= 1'b1;
        pulse(8'h00, 6);
        @(posedge clk);
        dir_sel[0] <= 1'b0;
        pulse(8'h00, 1);
        scan();
        @(posedge clk);
        dir_sel[0] <= 1'b1;
        pulse(8'h00, 1);
        scan();
        @(posedge clk);
        dir_sel <= '1;
        hs_down <= 1'b1;
        pulse(8'h64, 2);
        pulse(8'hDC, 2);
        pulse(8'h3F, 1);
        @(posedge clk);
        sp_from_data <= 1'b1;
        pulse(8'h46, 2);
        scan();
        power(9'h041);
        do_req(8'h00, 1'b0, 1'b0);
        do_req(8'h64, 1'b0, 1'b0);
        scan();
        pulse(8'h46, 1);
        do_req(8'h46, 1'b1, 1'b1);
        do_req(8'h46, 1'b1, 1'b0);
        scan();
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            dir_sel <= {$urandom, $urandom};
            hs_down <= 1'($urandom);
            sp_from_data <= 1'($urandom);
            sp_const <= VAL_W'($urandom % 7) - 32'h00000003;
            sp_lo <= 16'hFFFE + HALF_W'($urandom % 4);
            sp_hi <= ($urandom % 2) ? 16'hFFFF : 16'h0000;
            do_req(pick[$urandom % 4], 1'($urandom), ($urandom % 16) == 0);
            if (i % 8 == 7) begin
                scan();
            end
        end
        final_report();
    end
    // a hang shows as a run far past the few thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
endmodule
`default_nettype wire
